/* File: src/vsa_pkg.sv */
package vsa_pkg;

  // vector addresses; each holds the high byte, the low byte sits at the next address
  localparam logic [15:0] VSA_VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VSA_VEC_SWI       = 16'hfffc;
  localparam logic [15:0] VSA_VEC_EXT_REQ   = 16'hfffa;
  localparam logic [15:0] VSA_VEC_CLK_MON   = 16'hfff8;
  localparam logic [15:0] VSA_VEC_TA_CH0    = 16'hfff6;
  localparam logic [15:0] VSA_VEC_TA_CH1    = 16'hfff4;
  localparam logic [15:0] VSA_VEC_TA_OVF    = 16'hfff2;
  localparam logic [15:0] VSA_VEC_TB_CH0    = 16'hfff0;
  localparam logic [15:0] VSA_VEC_TB_CH1    = 16'hffee;
  localparam logic [15:0] VSA_VEC_TB_OVF    = 16'hffec;
  localparam logic [15:0] VSA_VEC_AS_ERR    = 16'hffea;
  localparam logic [15:0] VSA_VEC_AS_RX     = 16'hffe8;
  localparam logic [15:0] VSA_VEC_AS_TX     = 16'hffe6;
  localparam logic [15:0] VSA_VEC_KBD       = 16'hffe4;
  localparam logic [15:0] VSA_VEC_CONV      = 16'hffe2;
  localparam logic [15:0] VSA_VEC_SP_RX     = 16'hffe0;
  localparam logic [15:0] VSA_VEC_SP_TX     = 16'hffde;
  localparam logic [15:0] VSA_VEC_TIMEBASE  = 16'hffdc;

  // ram map
  localparam logic [15:0] VSA_RAM_LO0       = 16'h0040;
  localparam logic [15:0] VSA_RAM_HI0       = 16'h00ff;
  localparam logic [15:0] VSA_RAM_LO1       = 16'h0100;
  localparam logic [15:0] VSA_RAM_HI1       = 16'h023f;
  localparam int          VSA_RAM_BYTES     = 576;
  localparam int          VSA_PAGE0_BYTES   = 192;
  localparam logic [15:0] VSA_SP_RESET      = 16'h00ff;

  // stacked byte counts
  localparam logic [2:0]  VSA_INT_BYTES     = 3'h5;
  localparam logic [2:0]  VSA_CALL_BYTES    = 3'h2;

  // wishbone register byte offsets
  localparam logic [7:0]  VSA_REG_SP        = 8'h00;
  localparam logic [7:0]  VSA_REG_VEC       = 8'h04;
  localparam logic [7:0]  VSA_REG_PEND      = 8'h08;
  localparam logic [7:0]  VSA_REG_RAM_ADDR  = 8'h0c;
  localparam logic [7:0]  VSA_REG_RAM_DATA  = 8'h10;
  localparam logic [7:0]  VSA_REG_STAT      = 8'h14;
  localparam logic [7:0]  VSA_REG_ENABLE    = 8'h18;
  localparam logic [15:0] VSA_ENABLE_RESET  = 16'hffff;

  // status field positions
  localparam int          VSA_STAT_BUSY     = 0;
  localparam int          VSA_STAT_MISS     = 1;
  localparam int          VSA_STAT_SP_OUT   = 2;
  localparam int          VSA_VEC_VALID_BIT = 16;
  localparam int          VSA_VEC_SRC_LSB   = 24;

  // stack commands from the core
  typedef enum logic [2:0] {
    VSA_OP_NONE  = 3'h0,
    VSA_OP_PUSH  = 3'h1,
    VSA_OP_PULL  = 3'h2,
    VSA_OP_RSP   = 3'h3,
    VSA_OP_INT   = 3'h4,
    VSA_OP_CALL  = 3'h5
  } vsa_op_t;

  typedef struct packed {
    vsa_op_t     op;
    logic [7:0]  data;
    logic [15:0] pc;
    logic [7:0]  idx_lo;
    logic [7:0]  acc;
    logic [7:0]  ccr;
  } vsa_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  src;
    logic [15:0] hi_addr;
    logic [15:0] lo_addr;
  } vsa_vec_t;

endpackage

/* File: src/vsa_vector_sel.sv */
`timescale 1ns/1ns
module vsa_vector_sel
  import vsa_pkg::*;
(
  input  wire logic        reset_req_i,
  input  wire logic        swi_req_i,
  input  wire logic [16:1] flags_i,
  output vsa_vec_t         vec_o
);

  // source index 0 reset, 1 software, 2 external, then flag n gives n+1
  logic [4:0]  src;        // winning source
  logic [15:0] base;       // its high-byte address

  // fixed priority: lowest index wins, so reset beats everything
  always_comb
  begin
    src = 5'h0;
    if (reset_req_i)
      src = 5'h0;
    else if (swi_req_i)
      src = 5'h1;
    else
    begin
      src = 5'h1f;
      // scan from the weakest so the strongest pending flag is written last
      for (int n = 16; n >= 1; n--)
        if (flags_i[n])
          src = 5'(n + 1);
    end
  end

  // address table
  always_comb
  begin
    unique case (src)
      5'h00: base = VSA_VEC_RESET;
      5'h01: base = VSA_VEC_SWI;
      5'h02: base = VSA_VEC_EXT_REQ;
      5'h03: base = VSA_VEC_CLK_MON;
      5'h04: base = VSA_VEC_TA_CH0;
      5'h05: base = VSA_VEC_TA_CH1;
      5'h06: base = VSA_VEC_TA_OVF;
      5'h07: base = VSA_VEC_TB_CH0;
      5'h08: base = VSA_VEC_TB_CH1;
      5'h09: base = VSA_VEC_TB_OVF;
      5'h0a: base = VSA_VEC_AS_ERR;
      5'h0b: base = VSA_VEC_AS_RX;
      5'h0c: base = VSA_VEC_AS_TX;
      5'h0d: base = VSA_VEC_KBD;
      5'h0e: base = VSA_VEC_CONV;
      5'h0f: base = VSA_VEC_SP_RX;
      5'h10: base = VSA_VEC_SP_TX;
      5'h11: base = VSA_VEC_TIMEBASE;
      default: base = VSA_VEC_RESET;
    endcase
  end

  assign vec_o.valid   = (src != 5'h1f);
  assign vec_o.src     = src;
  assign vec_o.hi_addr = base;
  assign vec_o.lo_addr = base | 16'h0001;

endmodule

/* File: src/vsa_top.sv */
// Behaviour
// - timebase lowest priority, vector at ffdc/ffdd
// - serial peripheral tx ffde, rx ffe0
// - converter ffe2, keyboard ffe4, high byte even
// - async serial tx ffe6, rx ffe8, error ffea
// - second timer overflow ffec, ch1 ffee, ch0 fff0
// - first timer overflow fff2, channel 1 fff4
// - first timer ch0 fff6, clock monitor fff8
// - ram at 0040-00ff and 0100-023f only
// - sixteen bit stack pointer, resets to 00ff
// - 192 page zero ram bytes, directly addressable
// - interrupt entry pushes five bytes
// - index high byte never stacked
// - subroutine call pushes two return bytes
// - push decrements, pull increments stack pointer
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module vsa_top
  import vsa_pkg::*;
#(
  parameter int RAM_BYTES = VSA_RAM_BYTES
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // interrupt requesters
  input  wire logic        reset_req_i,
  input  wire logic        swi_req_i,
  input  wire logic [16:1] source_flag_i,
  output vsa_vec_t         vec_o,
  // stack commands from the core
  input  wire vsa_cmd_t    cmd_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  output logic      [7:0]  pull_data_o,
  output logic             pull_valid_o,
  output logic      [15:0] sp_o
);

  // only two states: how many bytes remain lives in push_left, not in the state
  // pushing sequencer, gray along idle -> push
  typedef enum logic [1:0] {
    VSA_ST_IDLE = 2'b00,
    VSA_ST_PUSH = 2'b01
  } vsa_state_t;

  vsa_state_t  state;          // sequencer state
  logic [15:0] sp;             // stack pointer
  logic [39:0] push_bytes;     // queued bytes, next one in the low byte
  logic [2:0]  push_left;      // bytes still to push
  logic [7:0]  ram [RAM_BYTES];// on-chip ram array
  logic [15:0] enable;         // software source enables
  logic [15:0] ram_addr;       // bus-side ram pointer
  logic        miss;           // last bus ram access hit no ram
  logic [31:0] rd_data;        // read mux
  logic        bus_req;        // request seen, not yet answered
  logic        ram_sel;        // bus targets the ram data port
  logic        bus_go;         // bus access happens this cycle
  logic        wr_go;          // bus write happens this cycle
  logic        st_push;        // sequencer writes ram this cycle
  logic        st_pull;        // single pull accepted this cycle
  logic [15:0] pull_addr;      // address a pull reads
  logic [15:0] sp_inc;         // sp plus one
  vsa_vec_t    vec;            // encoder result

  // the two windows meet at 0100, so one compare pair would do; keeping them
  // apart mirrors the map and keeps a later gap between them easy to add
  // ram decode used by both stack and bus
  function automatic logic is_ram(input logic [15:0] a);
    is_ram = ((a >= VSA_RAM_LO0) && (a <= VSA_RAM_HI0)) ||
             ((a >= VSA_RAM_LO1) && (a <= VSA_RAM_HI1));
  endfunction

  // the array is indexed from the bottom of the first window; entries above
  // the second window are never reached
  // byte address to array index; windows are contiguous from 0040
  function automatic logic [9:0] ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - VSA_RAM_LO0;
    ram_idx = d[9:0];
  endfunction

  // disabled flags drop out before the encoder, so a masked source can never
  // hide a weaker one that is enabled
  // masked sources feed the priority encoder
  vsa_vector_sel u_sel
  (
    .reset_req_i (reset_req_i),
    .swi_req_i   (swi_req_i),
    .flags_i     (source_flag_i & enable),
    .vec_o       (vec)
  );

  // vector register: the fetch address is a data output, so it comes from a
  // flip-flop and follows the request lines one clock later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vec_o <= '0;
    else
      vec_o <= vec;
  end

  // handshake terms
  // a request already answered is not taken again while ack is high
  assign bus_req     = cyc_i && stb_i && !ack_o;
  assign ram_sel     = (adr_i == VSA_REG_RAM_DATA);
  // the ram port belongs to the stack while it is busy, so the bus waits
  assign cmd_ready_o = (state == VSA_ST_IDLE);
  assign st_push     = (state == VSA_ST_PUSH);
  // only the ram data offset waits; every other offset answers at once
  assign bus_go      = bus_req && !(ram_sel && (st_push || cmd_valid_i));
  assign wr_go       = bus_go && we_i;
  assign st_pull     = cmd_ready_o && cmd_valid_i && (cmd_i.op == VSA_OP_PULL);
  assign sp_inc      = sp + 16'h0001;
  assign pull_addr   = sp_inc;

  // one fixed wait state for every access that is not stalled
  // wishbone answer one cycle after the request, dropped the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= bus_go;
  end

  // holds between reads so a slow master may sample it late
  // read data register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (bus_go && !we_i)
      dat_o <= rd_data;
  end

  // the array is read directly here, so a byte pushed in the previous cycle
  // is already visible to the bus
  // read mux, unmapped offsets read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (adr_i)
      VSA_REG_SP:       rd_data[15:0] = sp;
      VSA_REG_VEC:
      begin
        rd_data[15:0]                         = vec.hi_addr;
        rd_data[VSA_VEC_VALID_BIT]            = vec.valid;
        rd_data[VSA_VEC_SRC_LSB +: 5]         = vec.src;
      end
      VSA_REG_PEND:     rd_data[15:0] = source_flag_i;
      VSA_REG_RAM_ADDR: rd_data[15:0] = ram_addr;
      VSA_REG_RAM_DATA:
      begin
        // non-ram addresses read as zero
        if (is_ram(ram_addr))
          rd_data[7:0] = ram[ram_idx(ram_addr)];
      end
      VSA_REG_STAT:
      begin
        rd_data[VSA_STAT_BUSY]   = st_push;
        rd_data[VSA_STAT_MISS]   = miss;
        rd_data[VSA_STAT_SP_OUT] = !is_ram(sp);
      end
      VSA_REG_ENABLE:   rd_data[15:0] = enable;
      default:          rd_data = 32'h0000_0000;
    endcase
  end

  // reset and software interrupt are not maskable; only the flags pass here
  // source enable register, low two byte lanes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      enable <= VSA_ENABLE_RESET;
    else if (wr_go && (adr_i == VSA_REG_ENABLE))
    begin
      if (sel_i[0])
        enable[7:0] <= dat_i[7:0];
      if (sel_i[1])
        enable[15:8] <= dat_i[15:8];
    end
  end

  // limitation: no auto increment, software reloads the pointer per byte
  // bus ram pointer; any page zero byte is reachable through it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ram_addr <= VSA_RAM_LO0;
    else if (wr_go && (adr_i == VSA_REG_RAM_ADDR))
    begin
      if (sel_i[0])
        ram_addr[7:0] <= dat_i[7:0];
      if (sel_i[1])
        ram_addr[15:8] <= dat_i[15:8];
    end
  end

  // no separate clear: the next access that hits ram clears it
  // miss flag follows each bus ram data access
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      miss <= 1'b0;
    else if (bus_go && ram_sel)
      miss <= !is_ram(ram_addr);
  end

  // one edge moves the pointer once; the order below settles collisions,
  // and a bus load that loses still gets its ack
  // stack pointer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sp <= VSA_SP_RESET;
    else if (st_push)
      sp <= sp - 16'h0001;
    else if (cmd_ready_o && cmd_valid_i && (cmd_i.op == VSA_OP_RSP))
      sp <= VSA_SP_RESET;
    else if (st_pull)
      sp <= sp_inc;
    else if (wr_go && (adr_i == VSA_REG_SP))
    begin
      // full 64k reach by software load
      if (sel_i[0])
        sp[7:0] <= dat_i[7:0];
      if (sel_i[1])
        sp[15:8] <= dat_i[15:8];
    end
  end

  // the pointer leaves the block straight from its register
  assign sp_o = sp;

  // limitation: a sequence cannot be cut short, so the core may wait up to
  // five cycles on cmd_ready_o; in exchange the ram needs a single port
  // sequencer: one byte per cycle while pushing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= VSA_ST_IDLE;
      push_bytes <= 40'h00_0000_0000;
      push_left  <= 3'h0;
    end
    else
    begin
      unique case (state)
        VSA_ST_IDLE:
        begin
          if (cmd_valid_i)
          begin
            if (cmd_i.op == VSA_OP_INT)
            begin
              // five bytes, pc low first, ccr last
              // idx_lo only, index high byte left out
              push_bytes <= {cmd_i.ccr, cmd_i.acc, cmd_i.idx_lo,
                             cmd_i.pc[15:8], cmd_i.pc[7:0]};
              push_left  <= VSA_INT_BYTES;
              state      <= VSA_ST_PUSH;
            end
            else if (cmd_i.op == VSA_OP_CALL)
            begin
              push_bytes <= {24'h00_0000, cmd_i.pc[15:8], cmd_i.pc[7:0]};
              push_left  <= VSA_CALL_BYTES;
              state      <= VSA_ST_PUSH;
            end
            else if (cmd_i.op == VSA_OP_PUSH)
            begin
              push_bytes <= {32'h0000_0000, cmd_i.data};
              push_left  <= 3'h1;
              state      <= VSA_ST_PUSH;
            end
          end
        end
        VSA_ST_PUSH:
        begin
          push_bytes <= {8'h00, push_bytes[39:8]};
          push_left  <= push_left - 3'h1;
          if (push_left == 3'h1)
            state <= VSA_ST_IDLE;
        end
        default:
          state <= VSA_ST_IDLE;
      endcase
    end
  end

  // a push outside ram still moves the pointer, so the core sees the same
  // stack depth whatever the pointer holds
  // ram writes: stack first, then bus; pushes outside ram are dropped
  always_ff @(posedge clk_i)
  begin
    if (st_push)
    begin
      if (is_ram(sp))
        ram[ram_idx(sp)] <= push_bytes[7:0];
    end
    else if (wr_go && ram_sel && sel_i[0] && is_ram(ram_addr))
      // page zero bytes open to direct access
      ram[ram_idx(ram_addr)] <= dat_i[7:0];
  end

  // the byte read sits one above the pointer, the last one pushed; pulls
  // outside ram read zero rather than stale array contents
  // pull answer, valid the cycle after the pull is taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pull_data_o  <= 8'h00;
      pull_valid_o <= 1'b0;
    end
    else
    begin
      pull_valid_o <= st_pull;
      if (st_pull)
        pull_data_o <= is_ram(pull_addr) ? ram[ram_idx(pull_addr)] : 8'h00;
    end
  end

endmodule

/* File: verif/vsa_top_assertions.sv */
`timescale 1ns/1ns
module vsa_top_checker
  import vsa_pkg::*;
#(
  parameter int RAM_BYTES = VSA_RAM_BYTES
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        reset_req_i,
  input wire logic        swi_req_i,
  input wire logic [16:1] source_flag_i,
  input wire vsa_vec_t    vec_o,
  input wire vsa_cmd_t    cmd_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_ready_o,
  input wire logic        pull_valid_o,
  input wire logic [15:0] sp_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take; // a stack command is accepted at this edge
  assign take = cmd_valid_i && cmd_ready_o;
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  chk_sp_reset: assert property ($fell(rst_i) |-> sp_o == 16'h00ff && cmd_ready_o)
    else $error("stack pointer not at reset value");
  chk_rsp_load: assert property (take && cmd_i.op == VSA_OP_RSP |=> sp_o == 16'h00ff)
    else $error("reload did not restore pointer");
  chk_pull_inc: assert property (take && cmd_i.op == VSA_OP_PULL
    |=> pull_valid_o && sp_o == $past(sp_o) + 16'h1)
    else $error("pull did not step pointer up");
  chk_push_dec: assert property (take && cmd_i.op == VSA_OP_PUSH
    |=> !cmd_ready_o ##1 cmd_ready_o && sp_o == $past(sp_o, 2) - 16'h1)
    else $error("push did not step pointer down");
  chk_call_two: assert property (take && cmd_i.op == VSA_OP_CALL
    |=> !cmd_ready_o [*2] ##1 cmd_ready_o && sp_o == $past(sp_o, 3) - 16'h2)
    else $error("call did not stack two bytes");
  chk_int_five: assert property (take && cmd_i.op == VSA_OP_INT
    |=> !cmd_ready_o [*5] ##1 cmd_ready_o && sp_o == $past(sp_o, 6) - 16'h5)
    else $error("interrupt did not stack five bytes");
  chk_vec_pair: assert property (vec_o.valid
    |-> !vec_o.hi_addr[0] && vec_o.lo_addr == (vec_o.hi_addr | 16'h1))
    else $error("vector byte pair malformed");
  chk_vec_reset: assert property (reset_req_i |=> vec_o.valid && vec_o.hi_addr == 16'hfffe)
    else $error("reset vector not first");
  chk_vec_swi: assert property (swi_req_i && !reset_req_i |=> vec_o.hi_addr == 16'hfffc)
    else $error("software vector not second");
  chk_vec_lowest: assert property (source_flag_i == 16'h8000 && !reset_req_i && !swi_req_i
    |=> !vec_o.valid || vec_o.hi_addr == 16'hffdc)
    else $error("timebase vector wrong");
endmodule

bind vsa_top vsa_top_checker #(.RAM_BYTES(RAM_BYTES)) u_vsa_top_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .reset_req_i(reset_req_i), .swi_req_i(swi_req_i), .source_flag_i(source_flag_i),
  .vec_o(vec_o), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .pull_valid_o(pull_valid_o), .sp_o(sp_o)
);

/* File: verif/vsa_core_model.sv */
`timescale 1ns/1ns
module vsa_core_model
  import vsa_pkg::*;
(
  input  wire logic cmd_ready_i,
  input  wire logic clk_i,
  output vsa_cmd_t  cmd_o,
  output logic      cmd_valid_o
);
  logic slow; // alternates prompt and lazy issue
  initial
  begin
    slow = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // only the low index byte ever travels
  task automatic send(input vsa_op_t o, input logic [7:0] d, input logic [15:0] pc);
    repeat (1 + int'(slow)) @(posedge clk_i);
    slow = ~slow;
    cmd_o <= '{op: o, data: d, pc: pc, idx_lo: d, acc: ~d, ccr: d + 8'h1};
    cmd_valid_o <= 1'b1;
    // hold until an edge that sees the sequencer idle
    @(negedge clk_i);
    while (cmd_ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    // released fields carry the inverse, never a stale copy
    cmd_o <= ~cmd_o;
    @(negedge clk_i);
    while (cmd_ready_i !== 1'b1) @(negedge clk_i);
  endtask
endmodule

/* File: verif/vsa_top_test.sv */
`timescale 1ns/1ns
module vsa_top_test;
  import vsa_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        reset_req_i;
  logic        swi_req_i;
  logic [16:1] source_flag_i;
  vsa_vec_t    vec_o;
  vsa_cmd_t    cmd;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  pull_data;
  logic        pull_valid;
  logic [15:0] sp_o;
  logic [32:0] rd_q[$];   // bit 32 set when read data is compared
  logic [7:0]  pull_q[$]; // bytes expected from pulls
  logic [32:0] note;      // oldest bus note, taken at each ack
  logic [31:0] seed;
  logic [7:0]  b;
  logic [15:0] pc;
  logic [15:0] ram_a[8] = '{16'h003f, 16'h0040, 16'h0240, 16'h00ff,
                            16'h0000, 16'h0100, 16'hfff0, 16'h023f};
  int          mismatches;
  int          checks_done;

  vsa_top u_vsa_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .reset_req_i(reset_req_i), .swi_req_i(swi_req_i), .source_flag_i(source_flag_i),
    .vec_o(vec_o), .cmd_i(cmd), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .pull_data_o(pull_data), .pull_valid_o(pull_valid), .sp_o(sp_o)
  );
  vsa_core_model u_vsa_core_model (
    .cmd_ready_i(cmd_ready), .clk_i(clk_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle, held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [32:0] e);
    @(posedge clk_i);
    rd_q.push_back(e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h3;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    dat_i <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, {1'b1, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 33'h0);
  endtask

  task automatic pull(input logic [7:0] e);
    pull_q.push_back(e);
    u_vsa_core_model.send(VSA_OP_PULL, 8'h0, 16'h0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // results are matched against the oldest note left by the driver
  always @(negedge clk_i)
  begin
    if (ack_o === 1'b1)
    begin
      // an ack with no note left is a mismatch of its own
      note = (rd_q.size() > 0) ? rd_q.pop_front() : {1'b1, ~dat_o};
      if (note[32])
        chk("dat_o", note[31:0], dat_o);
    end
    if (pull_valid === 1'b1)
      chk("pull_data_o", (pull_q.size() > 0) ? {24'h0, pull_q.pop_front()} : {24'h0, ~pull_data},
          {24'h0, pull_data});
  end

  // hang guard, far above the few hundred cycles needed
  initial
  begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    summarize();
  end

  initial
  begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, reset_req_i, swi_req_i} = 5'h0;
    adr_i = 8'h0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    source_flag_i = 16'h0;
    seed = 32'h5391;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // unmapped offset acks, drops the write and reads zero
    wr(8'h1c, xs());
    rd(8'h1c, 32'h0);
    rd(VSA_REG_SP, 32'h00ff);
    rd(VSA_REG_ENABLE, 32'hffff);
    rd(VSA_REG_RAM_ADDR, 32'h0040);
    // random lower-priority noise must never win
    for (int n = 1; n <= 16; n++)
    begin
      @(posedge clk_i);
      source_flag_i <= (16'(xs()) & ~(16'hffff >> (17 - n))) | (16'h1 << (n - 1));
      repeat (2) @(negedge clk_i);
      chk("vec hi", 32'hfffa - 32'(2 * n - 2), {16'h0, vec_o.hi_addr});
      chk("vec lo", 32'hfffb - 32'(2 * n - 2), {16'h0, vec_o.lo_addr});
      chk("vec src", 32'(n + 1), {27'h0, vec_o.src});
    end
    wr(VSA_REG_ENABLE, 32'hfffe);
    @(posedge clk_i);
    source_flag_i <= 16'h0003;
    rd(VSA_REG_VEC, 32'h0301fff8);
    rd(VSA_REG_PEND, 32'h0003);
    swi_req_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("vec hi", 32'hfffc, {16'h0, vec_o.hi_addr});
    @(posedge clk_i);
    reset_req_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("vec hi", 32'hfffe, {16'h0, vec_o.hi_addr});
    @(posedge clk_i);
    {reset_req_i, swi_req_i} <= 2'h0;
    source_flag_i <= 16'h0;
    wr(VSA_REG_ENABLE, 32'hffff);
    // odd entries of the table are ram and keep their byte
    foreach (ram_a[i])
    begin
      b = 8'(xs());
      wr(VSA_REG_RAM_ADDR, {16'h0, ram_a[i]});
      wr(VSA_REG_RAM_DATA, {24'h0, b});
      rd(VSA_REG_RAM_DATA, (i % 2 == 1) ? {24'h0, b} : 32'h0);
      rd(VSA_REG_STAT, (i % 2 == 1) ? 32'h0 : 32'h2);
    end
    // every pointer used here stays inside ram
    wr(VSA_REG_SP, 32'h0150);
    rd(VSA_REG_SP, 32'h0150);
    u_vsa_core_model.send(VSA_OP_RSP, 8'h0, 16'h0);
    rd(VSA_REG_SP, 32'h00ff);
    b = 8'(xs());
    u_vsa_core_model.send(VSA_OP_PUSH, b, 16'h0);
    rd(VSA_REG_SP, 32'h00fe);
    pull(b);
    pc = 16'(xs());
    u_vsa_core_model.send(VSA_OP_CALL, 8'h0, pc);
    rd(VSA_REG_SP, 32'h00fd);
    pull(pc[15:8]);
    pull(pc[7:0]);
    u_vsa_core_model.send(VSA_OP_INT, b, pc);
    rd(VSA_REG_SP, 32'h00fa);
    pull(b + 8'h1);
    pull(~b);
    pull(b);
    pull(pc[15:8]);
    pull(pc[7:0]);
    rd(VSA_REG_SP, 32'h00ff);
    // mid-run reset must restore the pointer and the enables
    wr(VSA_REG_SP, 32'h0120);
    wr(VSA_REG_ENABLE, 32'h00ff);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(VSA_REG_SP, 32'h00ff);
    rd(VSA_REG_ENABLE, 32'hffff);
    repeat (2) @(posedge clk_i);
    chk("notes left", 32'h0, 32'(rd_q.size() + pull_q.size()));
    summarize();
  end
endmodule
